// File: src/amc_pkg.sv
// constants shared by the converter mode configuration port
package amc_pkg;

    // ======================================================================
    // register map
    // ======================================================================
    localparam logic [6:0] AMC_ADDR_SOFT_RESET_CONTROL    = 7'h00;
    localparam logic [6:0] AMC_ADDR_FORMAT_AND_POWER_DOWN = 7'h01;

    // reset values of the mode registers
    localparam logic [7:0] AMC_SOFT_RESET_CONTROL_RST     = 8'h00;
    localparam logic [7:0] AMC_FORMAT_AND_POWER_DOWN_RST  = 8'h00;

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int AMC_SOFT_RESET_BIT   = 7;  // soft_reset_control
    localparam int AMC_DUTY_OFF_BIT     = 7;  // format_and_power_down
    localparam int AMC_SCRAMBLE_BIT     = 6;
    localparam int AMC_SIGNED_BIT       = 5;
    localparam int AMC_SLEEP_BIT        = 4;
    localparam int AMC_NAP_LSB          = 0;
    localparam int AMC_NAP_WIDTH        = 4;

    // ======================================================================
    // serial frame layout
    // ======================================================================
    localparam logic [4:0] AMC_FRAME_EDGES  = 5'h10;  // edges sampled per frame
    localparam logic [4:0] AMC_HEADER_EDGES = 5'h08;  // direction plus address
    localparam int         AMC_WORD_BITS    = 15;     // frame minus direction bit
    localparam int         AMC_DATA_BITS    = 8;

    // ======================================================================
    // timing
    // ======================================================================
    localparam int AMC_CORE_CLK_HZ      = 10_000_000;
    localparam int AMC_SOFT_SLEEP_NS    = 1000;       // brief sleep of a soft reset
    // least time, so rounded up to whole cycles
    localparam int AMC_SOFT_SLEEP_CYC   =
        (AMC_SOFT_SLEEP_NS * (AMC_CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int AMC_SOFT_CNT_W       = 8;

endpackage

// File: src/amc_config_port.sv
// mode configuration port: serial register port, pin straps and power modes
//
// Operation
// R01: output disable stops all output pair drive
// R02: sleep from register bit or strap
// R03: host waits about 2ms after sleep
// R04: nap any channel subset, serial only
// R05: host waits 100 cycles after nap
// R06: host waits 50us more for settling
// R07: select pin picks straps or serial port
// R08: cs strap picks lanes and serialization
// R09: sck strap picks output drive current
// R10: sdi strap puts device to sleep
// R11: sdo strap enables internal termination
// R12: sample sdi on first 16 edges only
// R13: frame is direction, address, eight data
// R14: direction low writes, high reads back
// R15: readback leaves register untouched, ignores sdi
// R16: sdo open drain, host pulls up
// R17: host sends soft reset first
// R18: reset bit clears registers, self clears
// R19: soft reset sleeps briefly first
// R20: bit 7 turns duty stabilizer off
// R21: bit 6 turns scrambler on
// R22: scrambler xors lsb into upper bits
// R23: power field sleep bit, per channel nap
// R24: format bit selects two's complement
// R25: readback shifts msb first, last eight periods
`timescale 1ns/10ps
`default_nettype none

module amc_config_port
    import amc_pkg::*;
#(
    parameter int SAMPLE_W = 14                        // converter word width
)
(
    input  wire logic                core_clk_in,      // core clock, 10 MHz
    input  wire logic                reset_n_in,       // reset, synchronous in the core domain, asynchronous in the link domain
    input  wire logic                clk_en_in,        // core state freeze when low
    input  wire logic                programming_port_select_in, // high: straps
    input  wire logic                link_sck_in,      // serial clock, link domain
    input  wire logic                spi_cs_n_in,      // chip select / lane strap
    input  wire logic                spi_sdi_in,       // serial data / sleep strap
    input  wire logic                spi_sdo_in,       // sdo pin level / term strap
    output logic                     spi_sdo_out,      // sdo level when driven
    output logic                     spi_sdo_oe_out,   // sdo pull-down enable
    input  wire logic                output_disable_in,// output disable request
    input  wire logic [SAMPLE_W-1:0] sample_in,        // raw offset binary word
    output logic [SAMPLE_W-1:0]      sample_out,       // formatted output word
    output logic                     data_drive_en_out,// data pair drive on
    output logic                     data_clock_output_en_out, // clock pair on
    output logic                     frame_marker_output_en_out, // frame pair on
    output logic                     one_lane_out,     // 1: one lane, 14-bit
    output logic                     half_current_out, // 1: 1.75mA, 0: 3.5mA
    output logic                     term_enable_out,  // internal termination on
    output logic                     sleep_out,        // whole device asleep
    output logic [3:0]               nap_out,          // per channel nap
    output logic                     duty_stabilizer_off_out, // stabilizer off
    output logic                     soft_reset_busy_out // soft reset under way
);

    // ======================================================================
    // link domain: frame capture on the serial clock
    // ======================================================================
    // a frame is ended by its own chip select; the serial clock stands still
    // between frames, so nothing here waits for an edge after the last one
    logic        frame_clr;
    logic        link_rst;
    logic [4:0]  edge_cnt_q;
    logic [14:0] shift_in_q;
    logic        dir_read_q;
    logic [14:0] word_q;
    logic        write_tgl_q;
    logic [7:0]  sdo_shift_q;
    logic        sdo_oe_q;
    logic        frame_full;
    logic        last_edge;
    logic [7:0]  read_data;

    assign frame_clr  = spi_cs_n_in | programming_port_select_in | ~reset_n_in;
    assign link_rst   = ~reset_n_in;
    assign frame_full = (edge_cnt_q == AMC_FRAME_EDGES);
    assign last_edge  = (edge_cnt_q == AMC_FRAME_EDGES - 5'h01);

    // bit counter and input shifter; edges past the sixteenth are dropped
    always_ff @(posedge link_sck_in or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            edge_cnt_q <= 5'h00;
            shift_in_q <= 15'h0000;
            dir_read_q <= 1'b0;
        end
        else if (!frame_full)                                    // R12
        begin
            edge_cnt_q <= edge_cnt_q + 5'h01;
            shift_in_q <= {shift_in_q[13:0], spi_sdi_in};        // R13
            if (edge_cnt_q == 5'h00)
            begin
                dir_read_q <= spi_sdi_in;                        // R14
            end
        end
    end

    // completed write frames are held here and announced by a toggle;
    // a read frame never toggles, so the register cannot change
    always_ff @(posedge link_sck_in or posedge link_rst)
    begin
        if (link_rst)
        begin
            word_q      <= 15'h0000;
            write_tgl_q <= 1'b0;
        end
        else if (!frame_clr && last_edge && !dir_read_q)         // R15
        begin
            word_q      <= {shift_in_q[13:0], spi_sdi_in};       // R14
            write_tgl_q <= ~write_tgl_q;
        end
    end

    // readback source: the core registers only change after a write frame
    // has been handed over, or when the soft reset sleep ends, which can fall inside a read frame
    logic [6:0] read_addr;
    logic [7:0] soft_reset_control_q;
    logic [7:0] format_and_power_down_q;

    assign read_addr = shift_in_q[6:0];
    assign read_data =
        (read_addr == AMC_ADDR_SOFT_RESET_CONTROL)    ? soft_reset_control_q :
        (read_addr == AMC_ADDR_FORMAT_AND_POWER_DOWN) ? format_and_power_down_q :
                                                        8'h00;

    // open-drain readback: pull low for zeros, release for ones
    always_ff @(negedge link_sck_in or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            sdo_shift_q <= 8'h00;
            sdo_oe_q    <= 1'b0;
        end
        else if (dir_read_q && edge_cnt_q == AMC_HEADER_EDGES)   // R25
        begin
            sdo_shift_q <= {read_data[6:0], 1'b0};
            sdo_oe_q    <= ~read_data[7];                        // R16
        end
        else if (dir_read_q && edge_cnt_q > AMC_HEADER_EDGES && !frame_full)
        begin
            sdo_shift_q <= {sdo_shift_q[6:0], 1'b0};
            sdo_oe_q    <= ~sdo_shift_q[7];                      // R25
        end
        else
        begin
            sdo_oe_q    <= 1'b0;
        end
    end

    assign spi_sdo_oe_out = sdo_oe_q;                            // R16

    // ======================================================================
    // core domain: pin synchronisers
    // ======================================================================
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [2:0] tgl_sync_q;
    logic       par_mode;
    logic       strap_cs;
    logic       strap_sck;
    logic       strap_sdi;
    logic       strap_sdo;
    logic       write_evt;

    // two flops on the select, strap and serial pins before any logic looks at them; output_disable_in is not synchronised
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
            tgl_sync_q <= 3'h0;
        end
        else if (clk_en_in)
        begin
            pin_meta_q <= {programming_port_select_in, spi_cs_n_in, link_sck_in,
                           spi_sdi_in, spi_sdo_in};
            pin_sync_q <= pin_meta_q;
            tgl_sync_q <= {tgl_sync_q[1:0], write_tgl_q};
        end
    end

    // strap decode and write-frame event
    assign par_mode  = pin_sync_q[4];                            // R07
    assign strap_cs  = pin_sync_q[3];
    assign strap_sck = pin_sync_q[2];
    assign strap_sdi = pin_sync_q[1];
    assign strap_sdo = pin_sync_q[0];
    assign write_evt = (tgl_sync_q[2] != tgl_sync_q[1]) && !par_mode;

    // ======================================================================
    // core domain: mode registers and soft reset
    // ======================================================================
    logic [6:0]                wr_addr;
    logic [7:0]                wr_data;
    logic                      wr_soft_reset;
    logic                      wr_format;
    logic [AMC_SOFT_CNT_W-1:0] soft_cnt_q;
    logic                      soft_busy;

    assign wr_addr       = word_q[AMC_WORD_BITS-1:AMC_DATA_BITS];
    assign wr_data       = word_q[AMC_DATA_BITS-1:0];
    assign wr_soft_reset = write_evt && (wr_addr == AMC_ADDR_SOFT_RESET_CONTROL)
                           && wr_data[AMC_SOFT_RESET_BIT];
    assign wr_format     = write_evt && (wr_addr == AMC_ADDR_FORMAT_AND_POWER_DOWN);
    assign soft_busy     = (soft_cnt_q != '0);

    // soft reset clears the mode registers, sleeps, then drops its bit
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            soft_cnt_q              <= '0;
            soft_reset_control_q    <= AMC_SOFT_RESET_CONTROL_RST;
            format_and_power_down_q <= AMC_FORMAT_AND_POWER_DOWN_RST;
        end
        else if (clk_en_in)
        begin
            if (wr_soft_reset)
            begin
                soft_cnt_q              <= AMC_SOFT_CNT_W'(AMC_SOFT_SLEEP_CYC);  // R19
                soft_reset_control_q    <= 8'h80;                               // R18
                format_and_power_down_q <= AMC_FORMAT_AND_POWER_DOWN_RST;       // R18
            end
            else if (soft_busy)
            begin
                soft_cnt_q <= soft_cnt_q - AMC_SOFT_CNT_W'(1);
                if (soft_cnt_q == AMC_SOFT_CNT_W'(1))
                begin
                    soft_reset_control_q <= AMC_SOFT_RESET_CONTROL_RST;         // R18
                end
            end
            else if (wr_format)
            begin
                format_and_power_down_q <= wr_data;                             // R14
            end
        end
    end

    // ======================================================================
    // core domain: mode decode
    // ======================================================================
    logic                sleep_d;
    logic [3:0]          nap_d;
    logic                one_lane_d;
    logic                half_current_d;
    logic                term_d;
    logic                duty_off_d;
    logic                drive_en_d;
    logic                scramble_on;
    logic                signed_on;
    logic [SAMPLE_W-1:0] fmt_word;
    logic [SAMPLE_W-1:0] out_word;

    // straps only act in parallel mode; lane, current and termination stay
    // at their defaults in serial mode, since that register lives elsewhere
    assign sleep_d        = par_mode ? strap_sdi                              // R10
                          : (format_and_power_down_q[AMC_SLEEP_BIT] | soft_busy); // R02
    assign nap_d          = par_mode ? 4'h0                                   // R04
                          : format_and_power_down_q[AMC_NAP_LSB +: AMC_NAP_WIDTH]; // R23
    assign one_lane_d     = par_mode & strap_cs;                              // R08
    assign half_current_d = par_mode & strap_sck;                             // R09
    assign term_d         = par_mode & strap_sdo;                             // R11
    assign duty_off_d     = ~par_mode & format_and_power_down_q[AMC_DUTY_OFF_BIT]; // R20
    assign drive_en_d     = ~output_disable_in;                               // R01
    assign scramble_on    = ~par_mode & format_and_power_down_q[AMC_SCRAMBLE_BIT]; // R21
    assign signed_on      = ~par_mode & format_and_power_down_q[AMC_SIGNED_BIT];   // R24

    // two's complement is offset binary with the top bit turned round
    assign fmt_word = signed_on ? (sample_in ^ {1'b1, {(SAMPLE_W-1){1'b0}}})  // R24
                                : sample_in;
    // scrambler leaves the lsb alone so the far end can undo it
    assign out_word = scramble_on ? (fmt_word ^ {{(SAMPLE_W-1){fmt_word[0]}}, 1'b0}) // R22
                                  : fmt_word;

    // every output leaves through a flop
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            spi_sdo_out                <= 1'b0;
            sample_out                 <= '0;
            data_drive_en_out          <= 1'b0;
            data_clock_output_en_out   <= 1'b0;
            frame_marker_output_en_out <= 1'b0;
            one_lane_out               <= 1'b0;
            half_current_out           <= 1'b0;
            term_enable_out            <= 1'b0;
            sleep_out                  <= 1'b0;
            nap_out                    <= 4'h0;
            duty_stabilizer_off_out    <= 1'b0;
            soft_reset_busy_out        <= 1'b0;
        end
        else if (clk_en_in)
        begin
            spi_sdo_out                <= 1'b0;                  // R16
            sample_out                 <= out_word;
            data_drive_en_out          <= drive_en_d;            // R01
            data_clock_output_en_out   <= drive_en_d;            // R01
            frame_marker_output_en_out <= drive_en_d;            // R01
            one_lane_out               <= one_lane_d;
            half_current_out           <= half_current_d;
            term_enable_out            <= term_d;
            sleep_out                  <= sleep_d;
            nap_out                    <= nap_d;
            duty_stabilizer_off_out    <= duty_off_d;
            soft_reset_busy_out        <= soft_busy;
        end
    end

endmodule

`default_nettype wire

// File: dv/amc_config_port_properties.sv
// port assertions for the mode configuration port
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// checker, core clock domain only
// ======================================================================
module amc_config_port_properties (
    input wire logic       core_clk_in,                // core clock
    input wire logic       reset_n_in,                 // sync reset
    input wire logic       programming_port_select_in, // strap mode
    input wire logic       link_sck_in,                // current strap
    input wire logic       spi_cs_n_in,                // lane strap
    input wire logic       spi_sdi_in,                 // sleep strap
    input wire logic       spi_sdo_in,                 // term strap
    input wire logic       spi_sdo_out,                // sdo level
    input wire logic       spi_sdo_oe_out,             // sdo pull-down
    input wire logic       output_disable_in,          // pair disable
    input wire logic       data_drive_en_out,          // data pairs
    input wire logic       data_clock_output_en_out,   // clock pair
    input wire logic       frame_marker_output_en_out, // frame pair
    input wire logic       one_lane_out,               // lane mode
    input wire logic       half_current_out,           // drive current
    input wire logic       term_enable_out,            // termination
    input wire logic       sleep_out,                  // sleep
    input wire logic [3:0] nap_out,                    // nap per channel
    input wire logic       duty_stabilizer_off_out,    // stabilizer off
    input wire logic       soft_reset_busy_out         // soft reset
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    // straps pass two sync flops and a register, so five cycles of rest suffice
    pairs_off_a: assert property (output_disable_in [*2] |-> !data_drive_en_out &&
        !data_clock_output_en_out && !frame_marker_output_en_out) else $error("pairs driven");
    strap_lane_a: assert property ((programming_port_select_in && $stable(spi_cs_n_in)) [*5]
        |-> one_lane_out == spi_cs_n_in) else $error("lane strap not followed");
    strap_current_a: assert property ((programming_port_select_in && $stable(link_sck_in)) [*5]
        |-> half_current_out == link_sck_in) else $error("current strap not followed");
    strap_sleep_a: assert property ((programming_port_select_in && $stable(spi_sdi_in)) [*5]
        |-> sleep_out == spi_sdi_in) else $error("sleep strap not followed");
    strap_term_a: assert property ((programming_port_select_in && $stable(spi_sdo_in)) [*5]
        |-> term_enable_out == spi_sdo_in) else $error("term strap not followed");
    nap_serial_a: assert property (programming_port_select_in [*4] |-> nap_out == 4'h0)
        else $error("nap in strap mode");
    reset_sleep_a: assert property ($rose(soft_reset_busy_out) |-> ##[0:1] sleep_out)
        else $error("no sleep in soft reset");
    busy_span_a: assert property ($rose(soft_reset_busy_out) |->
        soft_reset_busy_out [*8] ##[1:4] !soft_reset_busy_out) else $error("busy length");
    reset_clear_a: assert property (soft_reset_busy_out && $past(soft_reset_busy_out, 2)
        |-> nap_out == 4'h0 && !duty_stabilizer_off_out) else $error("mode not cleared");
    sdo_release_a: assert property (spi_cs_n_in && $past(spi_cs_n_in) |-> !spi_sdo_oe_out)
        else $error("sdo held outside frame");
    sdo_low_a: assert property (spi_sdo_out == 1'b0)
        else $error("sdo driven high");
endmodule

bind amc_config_port amc_config_port_properties amc_config_port_properties_i (
    .core_clk_in, .reset_n_in, .programming_port_select_in, .link_sck_in, .spi_cs_n_in,
    .spi_sdi_in, .spi_sdo_in, .spi_sdo_out, .spi_sdo_oe_out, .output_disable_in,
    .data_drive_en_out, .data_clock_output_en_out, .frame_marker_output_en_out,
    .one_lane_out, .half_current_out, .term_enable_out, .sleep_out, .nap_out,
    .duty_stabilizer_off_out, .soft_reset_busy_out);

`default_nettype wire

// File: dv/amc_host_model.sv
// host controller model driving the four-wire configuration port
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// host model: serial frames or static straps
// ======================================================================
module amc_host_model (
    output logic      sck_out,     // link clock, idle low
    output logic      cs_n_out,    // chip select or lane strap
    output logic      sdi_out,     // data or sleep strap
    output logic      sdo_pin_out, // sdo wire or term strap
    input  wire logic sdo_oe_in    // device pulls sdo low
);
    logic strap_mode = 1'b0;
    logic term_strap = 1'b0;

    initial
    begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end

    // pull-up on the open-drain line, so a released pin reads high
    assign sdo_pin_out = strap_mode ? term_strap : !sdo_oe_in;

    task automatic straps(input logic [3:0] s);
        strap_mode = 1'b1;
        cs_n_out = s[0];
        sck_out = s[1];
        sdi_out = s[2];
        term_strap = s[3];
    endtask

    task automatic serial_mode();
        strap_mode = 1'b0;
        cs_n_out = 1'b1;
        sck_out = 1'b0;
    endtask

    // one frame, msb first; edges beyond sixteen carry toggling junk
    task automatic frame(input logic [15:0] word, input int edges, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_out = 1'b0;
        #40;
        for (int i = 0; i < edges; i++)
        begin
            sdi_out = (i < 16) ? word[15-i] : !sdi_out;
            #16;
            if (i >= 8 && i < 16)
                rd = {rd[6:0], sdo_pin_out};
            sck_out = 1'b1;
            #16;
            sck_out = 1'b0;
        end
        #40;
        cs_n_out = 1'b1;
        sdi_out = !sdi_out;
    endtask
endmodule

`default_nettype wire

// File: dv/tb_amc_config_port.sv
// self-checking bench for the mode configuration port
`timescale 1ns/10ps
`default_nettype none

// ======================================================================
// bench top
// ======================================================================
module tb_amc_config_port;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        port_sel = 1'b0;
    logic        out_dis = 1'b0;
    logic [13:0] sample = 14'h2a5b;
    logic        sck, cs_n, sdi, sdo_pin, sdo, sdo_oe, drv_en, dco_en, frm_en;
    logic        one_lane, half_cur, term_en, sleep_q, busy, duty_off;
    logic [3:0]  nap;
    logic [13:0] sample_q;
    int          fail_count = 0;
    int          tests_run = 0;

    amc_config_port amc_config_port_i (.core_clk_in(core_clk), .reset_n_in(reset_n),
        .clk_en_in(1'b1), .programming_port_select_in(port_sel), .link_sck_in(sck),
        .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_in(sdo_pin), .spi_sdo_out(sdo),
        .spi_sdo_oe_out(sdo_oe), .output_disable_in(out_dis), .sample_in(sample),
        .sample_out(sample_q), .data_drive_en_out(drv_en), .data_clock_output_en_out(dco_en),
        .frame_marker_output_en_out(frm_en), .one_lane_out(one_lane),
        .half_current_out(half_cur), .term_enable_out(term_en), .sleep_out(sleep_q),
        .nap_out(nap), .duty_stabilizer_off_out(duty_off), .soft_reset_busy_out(busy));

    amc_host_model amc_host_model_i (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi),
        .sdo_pin_out(sdo_pin), .sdo_oe_in(sdo_oe));

    // core clock, 100 ns
    always #50 core_clk = ~core_clk;

    // ==================================================================
    // helpers
    // ==================================================================
    function automatic logic [13:0] fmt_word(input logic [13:0] s, input logic [7:0] f);
        logic [13:0] t;
        t = f[5] ? {~s[13], s[12:0]} : s;
        return f[6] ? {t[13:1] ^ {13{t[0]}}, t[0]} : t;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // leave room for the register handover before the next frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
        logic [7:0] rd;
        amc_host_model_i.frame({1'b0, a, d}, n, rd);
        repeat (8) @(negedge core_clk);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rd;
        amc_host_model_i.frame({1'b1, a, 8'hff}, 16, rd);
        chk("readback", {8'h00, exp}, {8'h00, rd});
        repeat (6) @(negedge core_clk);
    endtask

    // ==================================================================
    // scenarios
    // ==================================================================
    task automatic t_soft_reset();
        logic [7:0] rd;
        amc_host_model_i.frame(16'h0080, 16, rd);
        for (int n = 0; n < 20 && busy !== 1'b1; n++) @(negedge core_clk);
        chk("sleep in reset", 16'h1, {15'h0, sleep_q});
        repeat (14) @(negedge core_clk);
        chk("modes after reset", 16'h0, {9'h0, busy, sleep_q, duty_off, nap});
        rd_chk(7'h00, 8'h00);
        rd_chk(7'h01, 8'h00);
    endtask

    task automatic t_format();
        logic [7:0] tbl [11] = '{8'h80, 8'h40, 8'h20, 8'h60, 8'h10, 8'h01,
                                 8'h02, 8'h04, 8'h08, 8'h0f, 8'h00};
        foreach (tbl[i])
        begin
            wr(7'h01, tbl[i], 16);
            chk("duty off", {15'h0, tbl[i][7]}, {15'h0, duty_off});
            chk("sleep", {15'h0, tbl[i][4]}, {15'h0, sleep_q});
            chk("nap", {12'h0, tbl[i][3:0]}, {12'h0, nap});
            chk("sample", {2'h0, fmt_word(sample, tbl[i])}, {2'h0, sample_q});
            rd_chk(7'h01, tbl[i]);
        end
    endtask

    task automatic t_frames();
        wr(7'h01, 8'h05, 20);
        rd_chk(7'h01, 8'h05);
        rd_chk(7'h01, 8'h05);
        wr(7'h01, 8'haa, 12);
        rd_chk(7'h01, 8'h05);
        wr(7'h12, 8'h55, 16);
        rd_chk(7'h12, 8'h00);
    endtask

    task automatic t_disable();
        @(posedge core_clk);
        out_dis <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk("pair enables", 16'h0, {13'h0, drv_en, dco_en, frm_en});
        @(posedge core_clk);
        out_dis <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("pair enables", 16'h7, {13'h0, drv_en, dco_en, frm_en});
    endtask

    // one strap at a time, then none; nap from the serial register must stay off
    task automatic t_parallel();
        logic [3:0] s;
        wr(7'h01, 8'h05, 16);
        for (int i = 0; i < 5; i++)
        begin
            s = (i < 4) ? 4'h1 << i : 4'h0;
            amc_host_model_i.straps(s);
            @(posedge core_clk);
            port_sel <= 1'b1;
            repeat (8) @(negedge core_clk);
            chk("straps", {12'h0, s}, {12'h0, term_en, sleep_q, half_cur, one_lane});
            chk("nap", 16'h0, {12'h0, nap});
        end
        amc_host_model_i.serial_mode();
        @(posedge core_clk);
        port_sel <= 1'b0;
        repeat (8) @(negedge core_clk);
        rd_chk(7'h01, 8'h05);
        chk("nap back", 16'h5, {12'h0, nap});
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==================================================================
    // main sequence and watchdog
    // ==================================================================
    initial
    begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (6) @(negedge core_clk);
        t_soft_reset();
        // no analog path in the model, so wake-up waits shrink to the handover gap
        t_format();
        t_frames();
        wr(7'h01, 8'h9f, 16);
        t_soft_reset();
        t_disable();
        t_parallel();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
endmodule

`default_nettype wire
